// ==== rtl/csfm_pkg.sv ====
/*
  Shared constants, types and helpers of the clock switch and fail-safe monitor.
  Assumes a 250 MHz system clock and a 32-bit APB register port.
*/
package csfm_pkg;

  localparam int unsigned CLK_HZ           = 250_000_000;
  localparam int unsigned LOW_POWER_RC_OSC_HZ          = 31_000;
  localparam int unsigned TICK_DIV_DFLT    = CLK_HZ / LOW_POWER_RC_OSC_HZ;
  localparam int unsigned DELAY_TICKS_DFLT = 64;
  localparam int unsigned MISS_TICKS_DFLT  = 2;

  localparam logic [11:0] CTRL_ADDR = 12'h000;
  localparam logic [11:0] STAT_ADDR = 12'h004;

  localparam int unsigned CUR_LSB  = 12;
  localparam int unsigned NEW_LSB  = 8;
  localparam int unsigned LOCK_BIT = 5;
  localparam int unsigned CF_BIT   = 3;
  localparam int unsigned KEEP_BIT = 1;
  localparam int unsigned REQ_BIT  = 0;
  localparam int unsigned HI_LANE  = 1;
  localparam int unsigned LO_LANE  = 0;

  localparam logic [7:0] KEY_HI1 = 8'h78;
  localparam logic [7:0] KEY_HI2 = 8'h9a;
  localparam logic [7:0] KEY_LO1 = 8'h46;
  localparam logic [7:0] KEY_LO2 = 8'h57;

  localparam logic [1:0] CFG_MON_ON = 2'h0;
  localparam int unsigned CFG_SW_BIT = 1;

  localparam logic [2:0] OSC_FRC     = 3'h0;
  localparam logic [2:0] OSC_FRC_PLL = 3'h1;
  localparam logic [2:0] OSC_PRI     = 3'h2;
  localparam logic [2:0] OSC_PRI_PLL = 3'h3;
  localparam logic [2:0] OSC_SEC     = 3'h4;
  localparam logic [2:0] OSC_LOW_POWER_RC_OSC    = 3'h5;
  localparam logic [2:0] OSC_FRC_DIV = 3'h7;

  localparam logic [1:0] SUB_EC = 2'h0;
  localparam logic [1:0] SUB_XT = 2'h1;
  localparam logic [1:0] SUB_HS = 2'h2;

  localparam int unsigned SRC_FRC  = 0;
  localparam int unsigned SRC_PRI  = 1;
  localparam int unsigned SRC_SEC  = 2;
  localparam int unsigned SRC_LOW_POWER_RC_OSC = 3;
  localparam int unsigned SRC_PLL  = 4;
  localparam int unsigned SRC_N    = 5;

  typedef enum logic [2:0] {SW_IDLE = 3'h1, SW_CHECK = 3'h2, SW_WAIT = 3'h4} csfm_sw_t;
  typedef enum logic [2:0] {UL_IDLE = 3'h1, UL_KEY1 = 3'h2, UL_OPEN = 3'h4} csfm_ul_t;

  function automatic logic is_pll(input logic [2:0] osc);
    return (osc == OSC_FRC_PLL) || (osc == OSC_PRI_PLL);
  endfunction

  function automatic logic is_pri(input logic [2:0] osc);
    return (osc == OSC_PRI) || (osc == OSC_PRI_PLL);
  endfunction

  // Crystal targets need the start-up timer; EC does not
  function automatic logic needs_ost(input logic [2:0] osc, input logic [1:0] sub);
    return (is_pri(osc) && (sub != SUB_EC)) || (osc == OSC_SEC);
  endfunction

  function automatic logic delay_src(input logic [2:0] osc, input logic [1:0] sub);
    return (is_pri(osc) && (sub != SUB_XT)) || (osc == OSC_SEC);
  endfunction

  function automatic logic [SRC_N-1:0] src_mask(input logic [2:0] osc);
    logic [SRC_N-1:0] m;
    m = '0;
    case (osc)
      OSC_FRC_PLL: begin
        m[SRC_FRC] = 1'b1;
        m[SRC_PLL] = 1'b1;
      end
      OSC_PRI:     m[SRC_PRI] = 1'b1;
      OSC_PRI_PLL: begin
        m[SRC_PRI] = 1'b1;
        m[SRC_PLL] = 1'b1;
      end
      OSC_SEC:     m[SRC_SEC] = 1'b1;
      OSC_LOW_POWER_RC_OSC:    m[SRC_LOW_POWER_RC_OSC] = 1'b1;
      default:     m[SRC_FRC] = 1'b1;
    endcase
    return m;
  endfunction

endpackage

// ==== rtl/csfm_unlock.sv ====
/*
  Keyed unlock tracker for one byte of the oscillator control register.
  Assumes i_access pulses once per completed APB access to that register.
*/
`timescale 1ns/1ps
module csfm_unlock
  import csfm_pkg::*;
#(
  parameter logic [7:0] KEY1 = 8'h00,
  parameter logic [7:0] KEY2 = 8'h00
) (
  input  wire logic       i_clock,
  input  wire logic       i_rst_n,
  input  wire logic       i_access,
  input  wire logic       i_lane_wr,
  input  wire logic [7:0] i_data,
  output logic            o_open
);

  csfm_ul_t st_q;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      st_q <= UL_IDLE;
    end else if (i_access) begin
      case (st_q)
        UL_IDLE: st_q <= (i_lane_wr && i_data == KEY1) ? UL_KEY1 : UL_IDLE;
        UL_KEY1: st_q <= (i_lane_wr && i_data == KEY2) ? UL_OPEN : UL_IDLE;
        UL_OPEN: st_q <= UL_IDLE;
        default: st_q <= UL_IDLE;
      endcase
    end
  end

  assign o_open = (st_q == UL_OPEN);

  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  property p_once;
    (st_q == UL_OPEN) && i_access |=> !o_open ##1 (st_q != UL_OPEN);
  endproperty
  a_once: assert property (p_once) else $error("unlock window outlived one access");

  property p_break;
    (st_q == UL_KEY1) && i_access && !(i_lane_wr && i_data == KEY2) |=> st_q == UL_IDLE;
  endproperty
  a_break: assert property (p_break) else $error("bad second key did not relock");

  property p_order;
    $rose(o_open) |-> $past(i_access && i_lane_wr && i_data == KEY2 && st_q == UL_KEY1);
  endproperty
  a_order: assert property (p_order) else $error("window opened without key pair");

endmodule

// ==== rtl/csfm_fail_mon.sv ====
/*
  Fail-safe clock monitor core: start delay, then heartbeat watch per LOW_POWER_RC_OSC tick.
  Assumes synchronised heartbeat edges and a one-cycle tick enable.
*/
`timescale 1ns/1ps
module csfm_fail_mon
  import csfm_pkg::*;
#(
  parameter int unsigned DELAY_TICKS = DELAY_TICKS_DFLT,
  parameter int unsigned MISS_TICKS  = MISS_TICKS_DFLT
) (
  input  wire logic i_clock,
  input  wire logic i_rst_n,
  input  wire logic i_arm,
  input  wire logic i_start,
  input  wire logic i_delay_applies,
  input  wire logic i_tick,
  input  wire logic i_hb_edge,
  input  wire logic i_src_ready,
  output logic      o_fail,
  output logic      o_delaying
);

  localparam int unsigned DW = $clog2(DELAY_TICKS + 1);
  localparam int unsigned MW = $clog2(MISS_TICKS + 1);

  logic [DW-1:0] dly_q;
  logic [MW-1:0] miss_q;
  logic          fail_q;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n || !i_arm) begin
      dly_q  <= '0;
      miss_q <= '0;
      fail_q <= 1'b0;
    end else begin
      fail_q <= 1'b0;
      if (i_start && i_delay_applies) begin
        dly_q  <= DW'(DELAY_TICKS);
        miss_q <= '0;
      end else if (dly_q != '0) begin
        if (i_tick) begin
          dly_q <= dly_q - 1'b1;
          if (dly_q == DW'(1) && !i_src_ready) begin
            fail_q <= 1'b1;
          end
        end
      end else if (i_hb_edge) begin
        miss_q <= '0;
      end else if (i_tick) begin
        if (miss_q == MW'(MISS_TICKS - 1)) begin
          fail_q <= 1'b1;
          miss_q <= '0;
        end else begin
          miss_q <= miss_q + 1'b1;
        end
      end
    end
  end

  assign o_fail     = fail_q;
  assign o_delaying = (dly_q != '0);

  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  property p_slow;
    i_arm && !i_start && dly_q == DW'(1) && i_tick && !i_src_ready |=> o_fail || !i_arm;
  endproperty
  a_slow: assert property (p_slow) else $error("expired delay missed slow start");

  property p_hold;
    i_arm && dly_q > DW'(1) |=> !o_fail;
  endproperty
  a_hold: assert property (p_hold) else $error("failure raised inside start delay");

endmodule

// ==== rtl/csfm_top.sv ====
/*
  Clock switch controller with fail-safe clock monitor, APB register slave.
  Assumes static configuration straps, asynchronous oscillator status pins,
  and a sleep level from core logic on i_clock.
*/
// Functional notes
// - monitor on only when config field is 00
// - LOW_POWER_RC_OSC kept running while monitoring, except sleep
// - clock failure raises trap, selects fast RC
// - monitor watches whatever source drives sysclk
// - failure loads current 000, sets fail, cancels
// - start delay after reset or wake, some sources
// - delay expiry before start counts as failure
// - watchdog clock untouched by clock failure
// - primary submode only from configuration straps
// - switching needs upper config bit zero
// - switching off: current follows initial config
// - switching off: request bit ignored, reads zero
// - high byte unlocked by 78h then 9Ah
// - low byte unlocked by 46h then 57h
// - unlocked byte writable for one access only
// - equal current and new: redundant, request cleared
// - valid request clears lock and fail flags
// - start target, wait timer or PLL lock
// - stable target: switch, clear request, copy field
// - old source powered down, with exceptions
// - absent target: wait forever, request stays set
// - clearing request aborts, stops timer and PLL
// - sleep aborts switch, keeps clock, clears request
`timescale 1ns/1ps
module csfm_top
  import csfm_pkg::*;
#(
  parameter int unsigned TICK_DIV    = TICK_DIV_DFLT,
  parameter int unsigned DELAY_TICKS = DELAY_TICKS_DFLT,
  parameter int unsigned MISS_TICKS  = MISS_TICKS_DFLT
) (
  input  wire logic             i_clock,
  input  wire logic             i_rst_n,
  input  wire logic             i_psel,
  input  wire logic             i_penable,
  input  wire logic             i_pwrite,
  input  wire logic [11:0]      i_paddr,
  input  wire logic [31:0]      i_pwdata,
  input  wire logic [3:0]       i_pstrb,
  output logic      [31:0]      o_prdata,
  output logic                  o_pready,
  output logic                  o_pslverr,
  input  wire logic [1:0]       i_clock_switch_monitor_config,
  input  wire logic [2:0]       i_initial_osc_config,
  input  wire logic [1:0]       i_primary_submode_config,
  input  wire logic             i_watchdog_enable,
  input  wire logic             i_sleep,
  input  wire logic             i_internal_system_reset,
  input  wire logic             i_sysclk_heartbeat,
  input  wire logic             i_osc_startup_timer_done,
  input  wire logic             i_pll_lock,
  input  wire logic             i_source_ready,
  output logic      [SRC_N-1:0] o_src_on,
  output logic      [2:0]       o_sysclk_sel,
  output logic      [1:0]       o_primary_submode,
  output logic                  o_osc_startup_timer_run,
  output logic                  o_clock_fail_trap
);

  localparam int unsigned TW = $clog2(TICK_DIV);

  logic [3:0]    s1_q, s2_q, s3_q, filt_q, filt_d;
  logic          hb_edge_q;
  logic [TW-1:0] tick_cnt_q;
  logic          tick_q;
  logic          loaded_q, isr_prev_q, sleep_prev_q;
  logic          pready_q, pslverr_q;
  logic [31:0]   prdata_q, rd_val;
  csfm_sw_t      st_q;
  logic          req_q, lock_q, cf_q, keep_q;
  logic [2:0]    cur_q, new_q;
  logic [SRC_N-1:0] on_q, on_d;
  logic          ost_run_q, trap_q;
  logic [2:0]    sel_q;
  logic [1:0]    sub_q;

  logic sw_en, mon_en, acc, setup, hit_ctrl, hit_stat, ctrl_acc;
  logic wr_hi, wr_lo, hi_open, lo_open, hi_ok, lo_ok, sw_set, sw_clr;
  logic fail, delaying, start, arm, ready, valid_go, busy;

  assign sw_en  = !i_clock_switch_monitor_config[CFG_SW_BIT];
  assign mon_en = (i_clock_switch_monitor_config == CFG_MON_ON);

  // Status pins are async: third stage must agree with second
  assign filt_d = (s2_q & s3_q) | (filt_q & ~(s2_q ^ s3_q));

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      s1_q      <= '0;
      s2_q      <= '0;
      s3_q      <= '0;
      filt_q    <= '0;
      hb_edge_q <= 1'b0;
    end else begin
      s1_q      <= {i_source_ready, i_pll_lock, i_osc_startup_timer_done, i_sysclk_heartbeat};
      s2_q      <= s1_q;
      s3_q      <= s2_q;
      filt_q    <= filt_d;
      hb_edge_q <= filt_d[0] ^ filt_q[0];
    end
  end

  // LOW_POWER_RC_OSC-rate enable; the monitor counts these instead of a second clock
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
    end else begin
      tick_q     <= (tick_cnt_q == TW'(TICK_DIV - 1));
      tick_cnt_q <= (tick_cnt_q == TW'(TICK_DIV - 1)) ? '0 : tick_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      loaded_q     <= 1'b0;
      isr_prev_q   <= 1'b1;
      sleep_prev_q <= 1'b0;
    end else begin
      loaded_q     <= 1'b1;
      // Hold the release edge until the monitor can arm
      isr_prev_q   <= loaded_q ? i_internal_system_reset : 1'b1;
      sleep_prev_q <= i_sleep;
    end
  end

  // APB: one wait state, answer on the second access cycle
  assign setup    = i_psel && i_penable && !pready_q;
  assign acc      = i_psel && i_penable && pready_q;
  assign hit_ctrl = (i_paddr == CTRL_ADDR);
  assign hit_stat = (i_paddr == STAT_ADDR);
  assign ctrl_acc = acc && hit_ctrl;
  assign wr_hi    = ctrl_acc && i_pwrite && i_pstrb[HI_LANE];
  assign wr_lo    = ctrl_acc && i_pwrite && i_pstrb[LO_LANE];

  always_comb begin
    rd_val = '0;
    if (hit_ctrl) begin
      rd_val[CUR_LSB +: 3] = cur_q;
      rd_val[NEW_LSB +: 3] = new_q;
      rd_val[LOCK_BIT]     = lock_q;
      rd_val[CF_BIT]       = cf_q;
      rd_val[KEEP_BIT]     = keep_q;
      rd_val[REQ_BIT]      = req_q && sw_en;
    end else if (hit_stat) begin
      rd_val[3:0] = {busy || (st_q == SW_CHECK), delaying, sw_en, mon_en};
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup && !(hit_ctrl || hit_stat);
      prdata_q  <= (setup && !i_pwrite) ? rd_val : '0;
    end
  end

  csfm_unlock #(
    .KEY1 (KEY_HI1),
    .KEY2 (KEY_HI2)
  ) u_unlock_hi (
    .i_clock   (i_clock),
    .i_rst_n   (i_rst_n),
    .i_access  (ctrl_acc),
    .i_lane_wr (wr_hi),
    .i_data    (i_pwdata[15:8]),
    .o_open    (hi_open)
  );

  csfm_unlock #(
    .KEY1 (KEY_LO1),
    .KEY2 (KEY_LO2)
  ) u_unlock_lo (
    .i_clock   (i_clock),
    .i_rst_n   (i_rst_n),
    .i_access  (ctrl_acc),
    .i_lane_wr (wr_lo),
    .i_data    (i_pwdata[7:0]),
    .o_open    (lo_open)
  );

  assign hi_ok    = wr_hi && hi_open;
  assign lo_ok    = wr_lo && lo_open;
  assign sw_set   = lo_ok && sw_en && i_pwdata[REQ_BIT];
  assign sw_clr   = lo_ok && !i_pwdata[REQ_BIT];
  assign busy     = (st_q == SW_WAIT);
  assign valid_go = (st_q == SW_CHECK) && (new_q != cur_q);
  assign ready    = (!needs_ost(new_q, i_primary_submode_config) || filt_q[1])
                 && (!is_pll(new_q) || filt_q[2]);

  assign start = (isr_prev_q && !i_internal_system_reset) || (sleep_prev_q && !i_sleep);
  assign arm   = mon_en && loaded_q && !i_sleep;

  csfm_fail_mon #(
    .DELAY_TICKS (DELAY_TICKS),
    .MISS_TICKS  (MISS_TICKS)
  ) u_fail_mon (
    .i_clock         (i_clock),
    .i_rst_n         (i_rst_n),
    .i_arm           (arm),
    .i_start         (start),
    .i_delay_applies (delay_src(cur_q, i_primary_submode_config)),
    .i_tick          (tick_q),
    .i_hb_edge       (hb_edge_q),
    .i_src_ready     (filt_q[3]),
    .o_fail          (fail),
    .o_delaying      (delaying)
  );

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      st_q  <= SW_IDLE;
      req_q <= 1'b0;
      cur_q <= OSC_FRC;
    end else if (!loaded_q || !sw_en) begin
      st_q  <= SW_IDLE;
      req_q <= 1'b0;
      cur_q <= i_initial_osc_config;
    end else if (fail) begin
      st_q  <= SW_IDLE;
      req_q <= 1'b0;
      cur_q <= OSC_FRC;
    end else if (i_sleep) begin
      st_q  <= SW_IDLE;
      req_q <= 1'b0;
    end else if (sw_set) begin
      st_q  <= SW_CHECK;
      req_q <= 1'b1;
    end else if (sw_clr) begin
      st_q  <= SW_IDLE;
      req_q <= 1'b0;
    end else begin
      case (st_q)
        SW_IDLE: st_q <= SW_IDLE;
        SW_CHECK: begin
          if (new_q == cur_q) begin
            req_q <= 1'b0;
            st_q  <= SW_IDLE;
          end else begin
            st_q  <= SW_WAIT;
          end
        end
        SW_WAIT: begin
          if (ready) begin
            cur_q <= new_q;
            req_q <= 1'b0;
            st_q  <= SW_IDLE;
          end
        end
        default: st_q <= SW_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      lock_q <= 1'b0;
      cf_q   <= 1'b0;
    end else begin
      lock_q <= !valid_go && filt_q[2] && on_q[SRC_PLL];
      // Hardware set beats a same-cycle software clear
      if (fail) begin
        cf_q <= 1'b1;
      end else if (valid_go || (lo_ok && !i_pwdata[CF_BIT])) begin
        cf_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      new_q  <= OSC_FRC;
      keep_q <= 1'b0;
    end else if (!loaded_q) begin
      new_q  <= i_initial_osc_config;
    end else begin
      if (hi_ok) begin
        new_q <= i_pwdata[NEW_LSB +: 3];
      end
      if (lo_ok) begin
        keep_q <= i_pwdata[KEEP_BIT];
      end
    end
  end

  always_comb begin
    on_d = src_mask(cur_q) | (busy ? src_mask(new_q) : '0);
    if (keep_q) begin
      on_d[SRC_SEC] = 1'b1;
    end
    if (i_watchdog_enable || (mon_en && !i_sleep)) begin
      on_d[SRC_LOW_POWER_RC_OSC] = 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      on_q      <= '0;
      ost_run_q <= 1'b0;
      trap_q    <= 1'b0;
      sel_q     <= OSC_FRC;
      sub_q     <= SUB_EC;
    end else begin
      on_q      <= on_d;
      ost_run_q <= busy && needs_ost(new_q, i_primary_submode_config);
      trap_q    <= fail;
      sel_q     <= cur_q;
      sub_q     <= i_primary_submode_config;
    end
  end

  assign o_prdata                = prdata_q;
  assign o_pready                = pready_q;
  assign o_pslverr               = pslverr_q;
  assign o_src_on                = on_q;
  assign o_sysclk_sel            = sel_q;
  assign o_primary_submode       = sub_q;
  assign o_osc_startup_timer_run = ost_run_q;
  assign o_clock_fail_trap       = trap_q;

  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  property p_fail_frc;
    loaded_q && sw_en && fail |=> cur_q == OSC_FRC && cf_q && !req_q ##1 o_sysclk_sel == OSC_FRC;
  endproperty
  a_fail_frc: assert property (p_fail_frc) else $error("failure did not force fast RC");

  property p_no_mon;
    (!mon_en) [*3] |-> !o_clock_fail_trap;
  endproperty
  a_no_mon: assert property (p_no_mon) else $error("trap with monitor disabled");

  property p_sw_off;
    loaded_q && !sw_en |=> !req_q && cur_q == $past(i_initial_osc_config);
  endproperty
  a_sw_off: assert property (p_sw_off) else $error("switching off but state moved");

  property p_redundant;
    !fail && !i_sleep && !sw_set && !sw_clr && st_q == SW_CHECK && new_q == cur_q
      |=> !req_q && st_q == SW_IDLE;
  endproperty
  a_redundant: assert property (p_redundant) else $error("redundant switch not dropped");

  property p_flags;
    valid_go && !fail |=> !lock_q && !cf_q;
  endproperty
  a_flags: assert property (p_flags) else $error("valid switch kept lock or fail flag");

  property p_commit;
    sw_en && !fail && !i_sleep && !sw_set && !sw_clr && busy && ready
      |=> cur_q == $past(new_q) && !req_q ##1 o_sysclk_sel == $past(new_q, 2);
  endproperty
  a_commit: assert property (p_commit) else $error("stable target not committed");

  property p_sleep;
    loaded_q && sw_en && i_sleep && st_q != SW_IDLE |=> st_q == SW_IDLE && !req_q
      && cur_q == $past(cur_q);
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep did not abort switch");

  property p_low_power_rc_osc;
    i_watchdog_enable |=> o_src_on[SRC_LOW_POWER_RC_OSC];
  endproperty
  a_low_power_rc_osc: assert property (p_low_power_rc_osc) else $error("watchdog lost its LOW_POWER_RC_OSC clock");

  property p_wait;
    busy && !ready && !fail && !i_sleep && !sw_clr && !sw_set |=> busy && req_q;
  endproperty
  a_wait: assert property (p_wait) else $error("switch left wait without source");

endmodule

// ==== tb/csfm_osc_model.sv ====
/*
  Behavioural oscillator side: heartbeat, start-up timer, PLL lock, source ready.
  Assumes the bench drives the dead and stall controls on the system clock.
*/
`timescale 1ns/1ps
module csfm_osc_model (
  input  wire logic       i_clock,
  input  wire logic       i_dead,
  input  wire logic       i_stall,
  input  wire logic [4:0] i_src_on,
  input  wire logic       i_ost_run,
  output logic            o_heartbeat,
  output logic            o_ost_done,
  output logic            o_pll_lock,
  output logic            o_source_ready
);
  logic [1:0] hb_q;
  logic [2:0] ost_q;
  logic [2:0] pll_q;
  initial begin
    hb_q        = 2'h0;
    ost_q       = 3'h0;
    pll_q       = 3'h0;
    o_heartbeat = 1'b0;
  end
  // Slow toggle so the three-flop synchroniser sees every edge
  // heartbeat never slow
  always_ff @(posedge i_clock) begin
    hb_q <= hb_q + 2'h1;
    if (hb_q == 2'h3 && !i_dead) begin
      o_heartbeat <= !o_heartbeat;
    end
  end
  always_ff @(posedge i_clock) begin
    ost_q <= !i_ost_run ? 3'h0 : (ost_q == 3'h4 ? ost_q : ost_q + 3'h1);
    pll_q <= !i_src_on[4] ? 3'h0 : (pll_q == 3'h4 ? pll_q : pll_q + 3'h1);
  end
  // Stall models a crystal that never starts
  assign o_ost_done     = (ost_q == 3'h4) && !i_stall;
  assign o_pll_lock     = (pll_q == 3'h4);
  assign o_source_ready = !i_dead && !i_stall;
endmodule

// ==== tb/csfm_top_tb.sv ====
/*
  Self-checking bench: APB register sequences for unlock, switch, failure, sleep.
  Assumes the oscillator model answers on the same clock.
*/
`timescale 1ns/1ps
module csfm_top_tb
  import csfm_pkg::*;
;
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwrite = 0, dead = 0, stall = 0, sleep = 0;
  logic isr = 0;
  logic err;
  logic [1:0] cfg = 2'h0;
  logic [1:0] psub;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r;
  logic [3:0] pstrb = '0;
  logic pready, pslverr, hb, ostd, lock, rdy, ost_run, trap;
  logic [4:0] src_on;
  logic [2:0] sel;
  int fails = 0, checks_done = 0, traps = 0;
  csfm_top #(.TICK_DIV(8), .DELAY_TICKS(3), .MISS_TICKS(2)) DUT (
    .i_clock(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(pen), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_clock_switch_monitor_config(cfg),
    .i_initial_osc_config(OSC_FRC_DIV), .i_primary_submode_config(SUB_XT),
    .i_watchdog_enable(1'b1), .i_sleep(sleep), .i_internal_system_reset(isr),
    .i_sysclk_heartbeat(hb), .i_osc_startup_timer_done(ostd), .i_pll_lock(lock),
    .i_source_ready(rdy), .o_src_on(src_on), .o_sysclk_sel(sel), .o_primary_submode(psub),
    .o_osc_startup_timer_run(ost_run), .o_clock_fail_trap(trap));
  csfm_osc_model PART (.i_clock(clk), .i_dead(dead), .i_stall(stall), .i_src_on(src_on),
    .i_ost_run(ost_run), .o_heartbeat(hb), .o_ost_done(ostd), .o_pll_lock(lock),
    .o_source_ready(rdy));
  initial forever #2 clk = !clk;
  // Trap is a one-cycle pulse: count every one
  always @(posedge clk) begin
    if (trap === 1'b1) begin
      traps <= traps + 1;
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One transfer; entered and left just after a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    psel <= 1; pen <= 0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge clk);
    pen <= 1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 0; pen <= 0;
    // Idle edge so the next call never drives psel twice in one step
    @(posedge clk);
  endtask
  task automatic keyed(input int lane, input logic [7:0] k1, k2, v);
    apb(1, CTRL_ADDR, {16'h0, k1, k1}, 4'h1 << lane);
    apb(1, CTRL_ADDR, {16'h0, k2, k2}, 4'h1 << lane);
    apb(1, CTRL_ADDR, {16'h0, v, v}, 4'h1 << lane);
  endtask
  task automatic start_sw(input logic [2:0] osc);
    keyed(HI_LANE, KEY_HI1, KEY_HI2, {5'h0, osc});
    // Bit 3 high so software never clears the fail flag here
    keyed(LO_LANE, KEY_LO1, KEY_LO2, 8'h09);
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    do begin
      apb(0, CTRL_ADDR, '0, '0);
      n++;
    end while (r[REQ_BIT] !== 1'b0 && n < 60);
    if (r[REQ_BIT] !== 1'b0) begin
      fails++;
      print_verdict();
    end
  endtask
  task automatic print_verdict();
    if (fails == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #20000;
    fails++;
    print_verdict();
  end
  initial begin
    int t;
    repeat (2) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    apb(0, CTRL_ADDR, '0, '0);
    chk("current", r[14:12], OSC_FRC_DIV); // start source
    chk("submode", psub, SUB_XT); // strap submode
    apb(0, STAT_ADDR, '0, '0);
    chk("status", r[1:0], 32'h3); // enables
    chk("err", err, 1'b0); // mapped status
    apb(1, CTRL_ADDR, 32'h0300, 4'h2);
    apb(0, CTRL_ADDR, '0, '0);
    chk("new", r[10:8], OSC_FRC_DIV); // locked write
    start_sw(OSC_PRI_PLL);
    wait_done();
    chk("current", r[14:12], OSC_PRI_PLL); // field copied
    chk("lock", r[LOCK_BIT], 1'b1); // PLL lock wait
    chk("sel", sel, OSC_PRI_PLL); // switch taken
    chk("frc_off", src_on[SRC_FRC], 1'b0); // old source off
    chk("traps", traps, 0); // healthy source quiet
    start_sw(OSC_PRI_PLL);
    wait_done();
    chk("current", r[14:12], OSC_PRI_PLL); // redundant
    dead <= 1;
    repeat (100) @(posedge clk);
    apb(0, CTRL_ADDR, '0, '0);
    chk("current", r[14:12], OSC_FRC); // forced fast RC
    chk("cf", r[CF_BIT], 1'b1); // fail flag
    chk("trap", traps != 0, 1'b1); // trap raised
    chk("low_power_rc_osc", src_on[SRC_LOW_POWER_RC_OSC], 1'b1); // LOW_POWER_RC_OSC kept
    dead <= 0;
    stall <= 1;
    repeat (40) @(posedge clk);
    start_sw(OSC_SEC);
    repeat (40) @(posedge clk);
    apb(0, CTRL_ADDR, '0, '0);
    chk("req", r[REQ_BIT], 1'b1); // waits forever
    chk("cf", r[CF_BIT], 1'b0); // flags cleared
    chk("ost_run", ost_run, 1'b1); // timer started
    keyed(LO_LANE, KEY_LO1, KEY_LO2, 8'h08);
    apb(0, CTRL_ADDR, '0, '0);
    chk("req", r[REQ_BIT], 1'b0); // software abort
    chk("ost_run", ost_run, 1'b0); // timer stopped
    start_sw(OSC_SEC);
    sleep <= 1;
    repeat (8) @(posedge clk);
    apb(0, CTRL_ADDR, '0, '0);
    chk("req", r[REQ_BIT], 1'b0); // sleep abort
    chk("current", r[14:12], OSC_FRC); // clock kept
    sleep <= 0;
    stall <= 0;
    repeat (8) @(posedge clk);
    start_sw(OSC_SEC);
    wait_done();
    chk("current", r[14:12], OSC_SEC); // secondary taken
    stall <= 1;
    isr <= 1;
    @(posedge clk);
    isr <= 0;
    repeat (4) @(posedge clk);
    apb(0, STAT_ADDR, '0, '0);
    chk("delaying", r[2], 1'b1); // start delay runs
    repeat (40) @(posedge clk);
    apb(0, CTRL_ADDR, '0, '0);
    chk("current", r[14:12], OSC_FRC); // slow start fails
    chk("cf", r[CF_BIT], 1'b1); // failure flagged
    stall <= 0;
    cfg <= 2'h3;
    repeat (4) @(posedge clk);
    start_sw(OSC_PRI);
    apb(0, CTRL_ADDR, '0, '0);
    chk("req", r[REQ_BIT], 1'b0); // request reads zero
    chk("current", r[14:12], OSC_FRC_DIV); // initial source
    chk("sel", sel, OSC_FRC_DIV); // clock follows straps
    apb(0, STAT_ADDR, '0, '0);
    chk("status", r[1:0], 32'h0); // both off
    t = traps;
    dead <= 1;
    repeat (40) @(posedge clk);
    chk("traps", traps, t); // monitor off
    print_verdict();
  end
endmodule
